// File: cfg_shadow_reg.sv
// Configuration register with a complemented shadow copy and a mismatch flag.
`timescale 1ns/100ps
module cfg_shadow_reg #(
	parameter int W = 24,
	parameter logic [W-1:0] RST = '1
) (
	input wire logic hclk, // System clock.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire logic load, // Capture load_value into both copies.
	input wire logic [W-1:0] load_value, // Value to store.
	input wire logic [W-1:0] upset, // Cell disturbance injection, xor into live copy.
	output logic [W-1:0] value, // Live register value.
	output logic mismatch // Live and shadow copies disagree.
);
	typedef struct packed {
		logic [W-1:0] live;
		logic [W-1:0] shadow;
		logic mismatch;
	} shadow_state_t;

	shadow_state_t cur;
	shadow_state_t next_cur;

	// The shadow only changes on a load, so any disturbed live bit breaks the complement.
	always_comb
	begin
		next_cur = cur;
		if (load)
		begin
			next_cur.live = load_value;
			next_cur.shadow = ~load_value;
		end
		else
		begin
			next_cur.live = cur.live ^ upset;
		end
		next_cur.mismatch = ((cur.live ^ cur.shadow) != {W{1'b1}});
	end

	// State register.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cur <= '{live: RST, shadow: ~RST, mismatch: 1'b0};
		else
			cur <= next_cur;
	end

	assign value = cur.live;
	assign mismatch = cur.mismatch;

	// A clean load leaves the copies in agreement two cycles on.
	a_shadow_clean: assert property (@(posedge hclk) disable iff (!hresetn)
		load && upset == '0 ##1 upset == '0 |=> !mismatch)
		else $error("shadow mismatch after clean load");

endmodule : cfg_shadow_reg

// File: cfg_word_protect.sv
// Configuration word decode, program memory protection and bus register file.
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
module cfg_word_protect
	import cwp_pkg::*;
(
	input wire logic hclk, // System clock, 250 MHz.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire logic hsel, // Slave select.
	input wire logic [31:0] haddr, // Byte address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write when high.
	input wire logic [2:0] hsize, // Transfer size, words only.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready.
	output logic hreadyout, // Always ready, no wait states.
	output logic [31:0] hrdata, // Read data, registered.
	output logic hresp, // Always OKAY.
	input wire logic [cwp_pkg::CFG_W-1:0] flash_cfg_word1, // Stored config word one.
	input wire logic [cwp_pkg::CFG_W-1:0] flash_cfg_word3, // Stored config word three.
	input wire logic [cwp_pkg::CFG_W-1:0] cfg_upset1, // Disturbance injection, word one.
	input wire logic [cwp_pkg::CFG_W-1:0] cfg_upset3, // Disturbance injection, word three.
	input wire logic scan_programming, // Pin: programming over scan port.
	input wire logic flash_req, // Write or erase request pulse.
	input wire logic [23:0] flash_addr, // Target word address.
	output logic flash_grant, // Request allowed, pulse.
	output logic flash_refused, // Request refused, pulse.
	output logic jtag_port_enable, // Scan test port enable.
	output logic code_protect_active, // Whole memory code protected.
	output logic debug_mode_boot, // Device came out of reset in debug mode.
	output logic program_pin_pair_one, // Emulator on pin pair one.
	output logic program_pin_pair_two, // Emulator on pin pair two.
	output logic program_pin_pair_three, // Emulator on pin pair three.
	output logic emulator_select_invalid, // Reserved pin select code stored.
	output logic watchdog_enable_cfg, // Watchdog enabled.
	output logic watchdog_window_mode, // Windowed watchdog.
	output logic watchdog_prescale_128, // Prescaler 1:128, else 1:32.
	output logic config_reset_req // Parity error device reset, pulse.
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		load_state_t load_state;
		logic scan_meta;
		logic scan_sync;
		logic ap_valid;
		logic ap_write;
		logic [7:0] ap_addr;
		logic [31:0] rdata;
		logic loaded;
		logic boot_debug;
		logic refused_flag;
		logic parity_flag;
		logic grant;
		logic refused;
		logic reset_req;
	} state_t;

	localparam state_t STATE_RST = '{
		load_state: ST_IDLE, scan_meta: 1'b0, scan_sync: 1'b0, ap_valid: 1'b0,
		ap_write: 1'b0, ap_addr: 8'h00, rdata: 32'h0000_0000, loaded: 1'b0,
		boot_debug: 1'b0, refused_flag: 1'b0, parity_flag: 1'b0, grant: 1'b0,
		refused: 1'b0, reset_req: 1'b0};

	state_t cur;
	state_t next_cur;
	logic [23:0] cw1;
	logic [23:0] cw3;
	logic [23:0] load_value1;
	logic mismatch1;
	logic mismatch3;
	logic cfg_load;
	logic [23:0] page_first;
	logic [23:0] page_last;
	logic [23:0] last_page_start;
	logic seg_active;
	logic seg_hit;
	logic cfg_page_hit;
	logic addr_protected;
	logic parity_error;

	// ----------------------------------------------------------------
	// Configuration registers with shadows
	// ----------------------------------------------------------------
	assign cfg_load = (cur.load_state == ST_FETCH);

	// Unimplemented bits are forced to 1 on each load, so they read back as 1 until a cell upset flips one.
	always_comb
	begin
		load_value1 = flash_cfg_word1 | CW1_ONES_MASK;
		if (cur.loaded && cur.scan_sync)
			load_value1[BIT_JTAG] = cw1[BIT_JTAG];
	end

	cfg_shadow_reg #(.W(CFG_W), .RST(CFG_UNPROG)) u_cw1 (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(cfg_load),
		.load_value(load_value1),
		.upset(cfg_upset1),
		.value(cw1),
		.mismatch(mismatch1)
	);

	cfg_shadow_reg #(.W(CFG_W), .RST(CFG_UNPROG)) u_cw3 (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(cfg_load),
		.load_value(flash_cfg_word3 | CW3_ONES_MASK),
		.upset(cfg_upset3),
		.value(cw3),
		.mismatch(mismatch3)
	);

	assign parity_error = mismatch1 | mismatch3;

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	// Scan port enable
	assign jtag_port_enable = cw1[BIT_JTAG];
	assign code_protect_active = !cw1[BIT_GCP];
	assign program_pin_pair_one = (cw1[BIT_EMU_HI:BIT_EMU_LO] == EMU_PAIR_ONE);
	assign program_pin_pair_two = (cw1[BIT_EMU_HI:BIT_EMU_LO] == EMU_PAIR_TWO);
	assign program_pin_pair_three = (cw1[BIT_EMU_HI:BIT_EMU_LO] == EMU_PAIR_THREE);
	assign emulator_select_invalid = (cw1[BIT_EMU_HI:BIT_EMU_LO] == 2'h0);
	assign watchdog_enable_cfg = cw1[BIT_WDT_EN];
	// Windowed only with enable; a stray window request is dropped.
	assign watchdog_window_mode = cw1[BIT_WDT_EN] && !cw1[BIT_WINDOW_DISABLE];
	assign watchdog_prescale_128 = cw1[BIT_PSA];
	assign debug_mode_boot = cur.boot_debug;

	// ----------------------------------------------------------------
	// Protected range
	// ----------------------------------------------------------------
	// Page bounds, inclusive of the selected page
	assign page_first = {7'h00, cw3[PAGE_LO +: PAGE_W], 9'h000};
	assign page_last = {7'h00, cw3[PAGE_LO +: PAGE_W], 9'h1FF};
	assign last_page_start = MEM_LAST_ADDR & ~PAGE_MASK;

	assign seg_active = !cw3[BIT_SEG_DIS];

	// Both segment directions compare against an inclusive bound.
	always_comb
	begin
		if (!seg_active)
			seg_hit = 1'b0;
		else if (cw3[BIT_SEG_END])
			seg_hit = (flash_addr >= page_first);
		else
			seg_hit = (flash_addr <= page_last);
	end

	// The last page holds the config words; general code protection covers them too.
	// Last page protect
	assign cfg_page_hit = (flash_addr >= last_page_start) &&
		(!cw3[BIT_CFG_PAGE] || !cw1[BIT_GCP]);

	assign addr_protected = !cw1[BIT_GENERAL_WRITE_PROTECT] || seg_hit || cfg_page_hit;

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = cur.rdata;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Reads are sampled in the address phase so read data is a flop in the data phase.
	always_comb
	begin
		logic set_refused;
		logic clr_refused;
		logic clr_parity;
		logic reload;
		set_refused = 1'b0;
		clr_refused = 1'b0;
		clr_parity = 1'b0;
		reload = 1'b0;
		next_cur = cur;

		// Pin synchroniser, first stage read by the second only.
		next_cur.scan_meta = scan_programming;
		next_cur.scan_sync = cur.scan_meta;

		// Data phase write effects.
		if (cur.ap_valid && cur.ap_write)
		begin
			if (cur.ap_addr == OFS_CTRL)
				reload = hwdata[CTRL_RELOAD];
			else if (cur.ap_addr == OFS_STATUS)
			begin
				clr_refused = hwdata[STAT_REFUSED];
				clr_parity = hwdata[STAT_PARITY];
			end
		end

		// Address phase capture.
		next_cur.ap_valid = hsel && hready && htrans[1];
		next_cur.ap_write = hwrite;
		next_cur.ap_addr = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
		if (hsel && hready && htrans[1] && !hwrite)
		begin
			if (haddr[31:8] != 24'h000000)
				next_cur.rdata = 32'h0000_0000;
			else if (haddr[7:0] == OFS_CW1)
				next_cur.rdata = {8'h00, cw1};
			else if (haddr[7:0] == OFS_CW3)
				next_cur.rdata = {8'h00, cw3};
			else if (haddr[7:0] == OFS_STATUS)
				next_cur.rdata = {28'h0000000, cur.scan_sync, cur.loaded,
					cur.parity_flag, cur.refused_flag};
			else
				next_cur.rdata = 32'h0000_0000;
		end

		// Load sequencer.
		case (cur.load_state)
			ST_IDLE:
				next_cur.load_state = ST_FETCH;
			ST_FETCH:
			begin
				next_cur.load_state = ST_RUN;
				next_cur.loaded = 1'b1;
				if (!cur.loaded)
					next_cur.boot_debug = !flash_cfg_word1[BIT_DEBUG];
			end
			ST_RUN:
				if (reload)
					next_cur.load_state = ST_FETCH;
			default:
				next_cur.load_state = ST_IDLE;
		endcase

		// Requests before the first load are refused, the words are not yet known.
		// Refuse protected request
		next_cur.grant = flash_req && cur.loaded && !addr_protected;
		next_cur.refused = flash_req && (!cur.loaded || addr_protected);
		set_refused = flash_req && (!cur.loaded || addr_protected);

		// Sticky flags, a set in the clearing cycle wins.
		next_cur.refused_flag = (cur.refused_flag && !clr_refused) || set_refused;
		next_cur.parity_flag = (cur.parity_flag && !clr_parity) || parity_error;

		next_cur.reset_req = parity_error && !cur.parity_flag;
	end

	// State register.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cur <= STATE_RST;
		else
			cur <= next_cur;
	end

	assign flash_grant = cur.grant;
	assign flash_refused = cur.refused;
	assign config_reset_req = cur.reset_req;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence clean_load_s;
		cfg_load && cfg_upset1 == '0;
	endsequence

	sequence scan_reload_s;
		clean_load_s and (cur.loaded && cur.scan_sync);
	endsequence

	a_jtag_from_flash: assert property (@(posedge hclk) disable iff (!hresetn)
		clean_load_s and !(cur.loaded && cur.scan_sync) |=>
		jtag_port_enable == $past(flash_cfg_word1[BIT_JTAG]))
		else $error("scan port enable not taken from flash word");

	a_jtag_scan_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		scan_reload_s |=> $stable(jtag_port_enable))
		else $error("scan port enable changed over scan programming");

	a_gcp_follow: assert property (@(posedge hclk) disable iff (!hresetn)
		clean_load_s |=> code_protect_active == !$past(flash_cfg_word1[BIT_GCP]))
		else $error("code protection does not follow flash word");

	a_general_write_protect_refuse: assert property (@(posedge hclk) disable iff (!hresetn)
		flash_req && cur.loaded && !cw1[BIT_GENERAL_WRITE_PROTECT] |=> flash_refused && !flash_grant)
		else $error("write granted under general write protection");

	a_seg_high: assert property (@(posedge hclk) disable iff (!hresetn)
		flash_req && !cw3[BIT_SEG_DIS] && cw3[BIT_SEG_END] && flash_addr >= page_first
		|=> flash_refused)
		else $error("upper segment write not refused");

	a_seg_low: assert property (@(posedge hclk) disable iff (!hresetn)
		flash_req && !cw3[BIT_SEG_DIS] && !cw3[BIT_SEG_END] && flash_addr <= page_last
		|=> flash_refused)
		else $error("lower segment write not refused");

	a_seg_off: assert property (@(posedge hclk) disable iff (!hresetn)
		flash_req && cur.loaded && cw3[BIT_SEG_DIS] && cw1[BIT_GENERAL_WRITE_PROTECT] && cw1[BIT_GCP] &&
		cw3[BIT_CFG_PAGE] |=> flash_grant)
		else $error("write refused with all protection off");

	a_cfg_page: assert property (@(posedge hclk) disable iff (!hresetn)
		flash_req && !cw3[BIT_CFG_PAGE] && flash_addr >= last_page_start |=> flash_refused)
		else $error("last page write not refused");

	a_grant_excl: assert property (@(posedge hclk) disable iff (!hresetn)
		flash_refused |-> !flash_grant ##0 cur.refused_flag)
		else $error("refused request granted or not reported");

	a_parity_reset: assert property (@(posedge hclk) disable iff (!hresetn)
		cur.load_state == ST_RUN && cfg_upset1 != '0 && !cur.parity_flag
		|-> ##[1:3] config_reset_req)
		else $error("disturbed word did not request reset");

	a_window_needs: assert property (@(posedge hclk) disable iff (!hresetn)
		watchdog_window_mode |-> watchdog_enable_cfg && !cw1[BIT_WINDOW_DISABLE])
		else $error("windowed watchdog without enable");

	a_emu_onehot: assert property (@(posedge hclk) disable iff (!hresetn)
		$onehot({program_pin_pair_one, program_pin_pair_two, program_pin_pair_three,
		emulator_select_invalid}))
		else $error("emulator pin routing not one-hot");

	a_boot_stable: assert property (@(posedge hclk) disable iff (!hresetn)
		cur.loaded && $past(cur.loaded) |-> $stable(debug_mode_boot))
		else $error("boot mode changed after reset");

	// Checked right after a load, since a later cell upset may legally flip any live bit.
	a_unused_ones: assert property (@(posedge hclk) disable iff (!hresetn)
		cfg_load |=>
		(cw1 & CW1_ONES_MASK) == CW1_ONES_MASK)
		else $error("unimplemented bits not reading one");

endmodule : cfg_word_protect

// File: cfg_word_protect_tb.sv
// Self-checking bench for the configuration word protection block.
`timescale 1ns/100ps
module cfg_word_protect_tb;
	import cwp_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, scan_programming, go, boot, anyref, r;
	logic flash_req, flash_grant, flash_refused, config_reset_req;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [9:0] dec;
	logic [23:0] prog1, prog3, go_addr, w1, w3, cfg_upset1, cfg_upset3, flash_addr, f, b;
	logic [23:0] flash_cfg_word1, flash_cfg_word3;
	logic [23:0] al [9];
	int n_fail, cmp_count, i, j;

	cfg_word_protect i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.flash_cfg_word1(flash_cfg_word1), .flash_cfg_word3(flash_cfg_word3),
		.cfg_upset1(cfg_upset1), .cfg_upset3(cfg_upset3), .scan_programming(scan_programming),
		.flash_req(flash_req), .flash_addr(flash_addr), .flash_grant(flash_grant),
		.flash_refused(flash_refused), .jtag_port_enable(dec[0]), .code_protect_active(dec[1]),
		.debug_mode_boot(dec[2]), .program_pin_pair_one(dec[3]), .program_pin_pair_two(dec[4]),
		.program_pin_pair_three(dec[5]), .emulator_select_invalid(dec[6]),
		.watchdog_enable_cfg(dec[7]), .watchdog_window_mode(dec[8]),
		.watchdog_prescale_128(dec[9]), .config_reset_req(config_reset_req));

	flash_prog_model i_flash (.hclk(hclk), .prog1(prog1), .prog3(prog3), .go(go),
		.go_addr(go_addr), .flash_cfg_word1(flash_cfg_word1),
		.flash_cfg_word3(flash_cfg_word3), .flash_req(flash_req), .flash_addr(flash_addr));

	// ----------------------------------------------------------------
	// Reference model and bus tasks
	// ----------------------------------------------------------------
	function logic [9:0] model_dec(input logic [23:0] w);
		model_dec = {w[4], w[7] & ~w[6], w[7], w[9:8] == 2'h0, w[9:8] == 2'h1,
			w[9:8] == 2'h2, w[9:8] == 2'h3, boot, ~w[13], w[14]};
	endfunction : model_dec

	// Protection model; the last page also guards the configuration source words.
	function logic refuse(input logic [23:0] ad);
		logic [23:0] fp;
		fp = {7'h00, w3[7:0], 9'h000};
		refuse = !w1[12] || (!w3[10] && (w3[8] ? ad >= fp : ad <= (fp | PAGE_MASK)))
			|| (ad >= (MEM_LAST_ADDR & ~PAGE_MASK) && (!w3[9] || !w1[13]));
	endfunction : refuse

	task check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask : check

	task stop_test();
		if (n_fail == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test

	// Single word transfer; the address phase is held until ready is seen.
	task ahb(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= ad;
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
	endtask : ahb

	task reload();
		ahb(1'b1, {24'h000000, OFS_CTRL}, 32'h00000001);
		repeat (4) @(posedge hclk);
		w1 = flash_cfg_word1 | CW1_ONES_MASK;
		w3 = flash_cfg_word3 | CW3_ONES_MASK;
	endtask : reload

	task check_dec();
		check({22'h0, dec}, {22'h0, model_dec(w1)});
		check({30'h0, dec[8:7]}, {30'h0, w1[7] & ~w1[6], w1[7]});
		check({31'h0, dec[9]}, {31'h0, w1[4]});
		ahb(1'b0, {24'h0, OFS_CW1}, 32'h0);
		check(rd, {8'h00, w1});
		ahb(1'b0, {24'h0, OFS_CW3}, 32'h0);
		check(rd, {8'h00, w3});
	endtask : check_dec

	// Request goes out one edge after go, the answer is due one edge later.
	task freq(input logic [23:0] ad);
		go <= 1'b1;
		go_addr <= ad;
		@(posedge hclk);
		go <= 1'b0;
		@(posedge hclk);
		#1;
		r = refuse(ad);
		anyref |= r;
		check({31'h0, flash_refused}, {31'h0, r});
		check({31'h0, flash_grant}, {31'h0, ~r});
		// The answer stands for one cycle only; realign to the edge before the next call.
		@(posedge hclk);
	endtask : freq

	// ----------------------------------------------------------------
	// Clock, watchdog and test sequence
	// ----------------------------------------------------------------
	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	// The run needs under a thousand cycles; this span leaves a wide margin.
	initial
	begin
		#100000;
		n_fail++;
		stop_test();
	end

	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		scan_programming = 1'b0;
		go = 1'b0;
		go_addr = 24'h0;
		cfg_upset1 = 24'h0;
		cfg_upset3 = 24'h0;
		n_fail = 0;
		cmp_count = 0;
		anyref = 1'b0;
		void'($urandom(32'h9658));
		prog1 = 24'($urandom);
		prog3 = 24'($urandom);
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		w1 = flash_cfg_word1 | CW1_ONES_MASK;
		w3 = flash_cfg_word3 | CW3_ONES_MASK;
		boot = ~w1[11];
		check_dec();
		// Random words, every legal pin pair code, boundary addresses around the page.
		for (i = 0; i < 16; i++)
		begin
			prog1 = 24'($urandom);
			prog1[9:8] = 2'(3 - i % 3);
			prog1[12] = (i != 15);
			prog3 = 24'($urandom);
			reload();
			check_dec();
			f = {7'h00, w3[7:0], 9'h000};
			al = '{24'h0, f, f - 24'h1, f | PAGE_MASK, (f | PAGE_MASK) + 24'h1,
				MEM_LAST_ADDR & ~PAGE_MASK, (MEM_LAST_ADDR & ~PAGE_MASK) - 24'h1,
				MEM_LAST_ADDR, 24'($urandom) & MEM_LAST_ADDR};
			for (j = 0; j < 9; j++)
				freq(al[j]);
			ahb(1'b0, {24'h0, OFS_STATUS}, 32'h0);
			check(rd, {28'h0, 2'h1, 1'b0, anyref});
			ahb(1'b1, {24'h0, OFS_STATUS}, 32'h00000001);
			anyref = 1'b0;
		end
		// A write to a read-only word changes nothing; reads of unmapped places return nothing.
		ahb(1'b1, {24'h0, OFS_CW1}, 32'h0);
		ahb(1'b0, {24'h0, OFS_CW1}, 32'h0);
		check(rd, {8'h00, w1});
		ahb(1'b0, 32'h00000100, 32'h0);
		check(rd, 32'h0);
		ahb(1'b0, 32'h00000010, 32'h0);
		check(rd, 32'h0);
		// Scan-port programming must not alter the port enable.
		scan_programming <= 1'b1;
		prog1 <= prog1 ^ 24'h004000;
		repeat (3) @(posedge hclk);
		reload();
		check({31'h0, dec[0]}, {31'h0, ~w1[14]});
		ahb(1'b0, {24'h0, OFS_STATUS}, 32'h0);
		check({31'h0, rd[3]}, 32'h1);
		scan_programming <= 1'b0;
		repeat (3) @(posedge hclk);
		reload();
		check({31'h0, dec[0]}, {31'h0, w1[14]});
		// One disturbed cell in each word gives exactly one reset request.
		for (i = 0; i < 2; i++)
		begin
			b = 24'h000001 << ($urandom % 24);
			cfg_upset1 <= (i == 0) ? b : 24'h0;
			cfg_upset3 <= (i == 1) ? b : 24'h0;
			@(posedge hclk);
			cfg_upset1 <= 24'h0;
			cfg_upset3 <= 24'h0;
			j = 0;
			repeat (4)
			begin
				@(posedge hclk);
				#1;
				j += int'(config_reset_req === 1'b1);
			end
			check(j, 32'h1);
			ahb(1'b0, {24'h0, OFS_STATUS}, 32'h0);
			check({31'h0, rd[1]}, 32'h1);
			reload();
			ahb(1'b1, {24'h0, OFS_STATUS}, 32'h00000002);
			ahb(1'b0, {24'h0, OFS_STATUS}, 32'h0);
			check({31'h0, rd[1]}, 32'h0);
		end
		stop_test();
	end
endmodule : cfg_word_protect_tb

// File: cwp_pkg.sv
// Constants, field layout and types for the configuration word protection block.
package cwp_pkg;

	// ----------------------------------------------------------------
	// Configuration word one field positions
	// ----------------------------------------------------------------
	localparam int CFG_W = 24;
	localparam int BIT_RSV15 = 15;
	localparam int BIT_JTAG = 14;
	localparam int BIT_GCP = 13;
	localparam int BIT_GENERAL_WRITE_PROTECT = 12;
	localparam int BIT_DEBUG = 11;
	localparam int BIT_RSV10 = 10;
	localparam int BIT_EMU_HI = 9;
	localparam int BIT_EMU_LO = 8;
	localparam int BIT_WDT_EN = 7;
	localparam int BIT_WINDOW_DISABLE = 6;
	localparam int BIT_PSA = 4;
	localparam logic [23:0] CW1_ONES_MASK = 24'hFF0020;
	localparam logic [23:0] CFG_UNPROG = 24'hFFFFFF;

	// ----------------------------------------------------------------
	// Emulator pin pair codes
	// ----------------------------------------------------------------
	localparam logic [1:0] EMU_PAIR_ONE = 2'h3;
	localparam logic [1:0] EMU_PAIR_TWO = 2'h2;
	localparam logic [1:0] EMU_PAIR_THREE = 2'h1;

	// ----------------------------------------------------------------
	// Configuration word three field positions
	// ----------------------------------------------------------------
	localparam int PAGE_LO = 0;
	localparam int PAGE_W = 8;
	localparam int BIT_SEG_END = 8;
	localparam int BIT_CFG_PAGE = 9;
	localparam int BIT_SEG_DIS = 10;
	localparam logic [23:0] CW3_ONES_MASK = 24'hFFF800;

	// ----------------------------------------------------------------
	// Program memory geometry
	// ----------------------------------------------------------------
	localparam logic [23:0] PAGE_MASK = 24'h0001FF;
	localparam logic [23:0] MEM_LAST_ADDR = 24'h01FFFF;

	// ----------------------------------------------------------------
	// Bus register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CW1 = 8'h00;
	localparam logic [7:0] OFS_CW3 = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam int CTRL_RELOAD = 0;
	localparam int STAT_REFUSED = 0;
	localparam int STAT_PARITY = 1;
	localparam int STAT_LOADED = 2;
	localparam int STAT_SCAN = 3;

	// Load sequencer, Gray coded along idle, fetch, run.
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_FETCH = 2'h1,
		ST_RUN = 2'h3
	} load_state_t;

endpackage : cwp_pkg

// File: flash_prog_model.sv
// Behavioural flash controller and programmer facing the protection block.
`timescale 1ns/100ps
module flash_prog_model (
	input wire logic hclk, // System clock.
	input wire logic [23:0] prog1, // Word one the bench wants stored.
	input wire logic [23:0] prog3, // Word three the bench wants stored.
	input wire logic go, // Issue one request on the next edge.
	input wire logic [23:0] go_addr, // Address for that request.
	output logic [23:0] flash_cfg_word1, // Stored word one.
	output logic [23:0] flash_cfg_word3, // Stored word three.
	output logic flash_req, // Write or erase request pulse.
	output logic [23:0] flash_addr // Request address.
);
	// Storage and request issue; every change lands just after a rising edge.
	always @(posedge hclk)
	begin
		// legal reserved bits, window only with watchdog
		flash_cfg_word1 <= (prog1 & ~24'h008000) | 24'h000400 | {16'h0000, ~prog1[6], 7'h00};
		flash_cfg_word3 <= prog3;
		flash_req <= go;
		// An unqualified address shows the inverse, so a stale value cannot pass.
		flash_addr <= go ? go_addr : ~go_addr;
	end
endmodule : flash_prog_model
